/* hw/mmn_core.sv */
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "mmn_consts.svh"

module mmn_core
	import mmn_pkg::*;
#(
	parameter int MEM_DEPTH = 4096
)
(
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Execution state.
	output logic busy
);
	import mmn_pkg::*;

	localparam int IW = $clog2(MEM_DEPTH);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------

	mmn_state_t state_reg; // Phase sequencer.
	logic busy_reg; // Registered copy of "not idle", so the busy pin comes from a flop.
	mmn_op_t op_reg; // Operation decoded in phase one.
	logic [15:0] instr_reg; // Instruction word under execution.
	logic [7:0] acc_reg; // Working register.
	logic [7:0] bank_selector_register; // Bank selector.
	logic [7:0] product_high_byte;
	logic [7:0] product_low_byte;
	logic [4:0] status_reg; // N OV Z DC C.
	logic ext_reg; // Extended instruction set enable.
	logic [11:0] index_reg; // Base of the indexed literal offset window.
	logic [11:0] maddr_reg; // Software pointer into file memory.
	logic [11:0] addr_reg; // Operand address latched in phase two.
	logic [7:0] opnd_reg; // Operand read in phase two.
	mmn_alu_t alu_reg; // Result processed in phase three.
	logic [7:0] mem [MEM_DEPTH]; // File registers as flip-flops.
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// ----------------------------------------------------------------
	// Decode and operand addressing
	// ----------------------------------------------------------------

	logic [7:0] fval; // Eight-bit file address or literal.
	logic abit; // Bank bit.
	logic [11:0] eff_addr; // Resolved operand address.
	mmn_op_t op_next;
	mmn_alu_t alu_out;
	logic [31:0] rd_mux;
	logic hit;
	logic access; // Completing APB transfer this edge.
	logic wr;

	assign fval = instr_reg[7:0];
	assign abit = instr_reg[8];

	// Opcode classes; only the listed patterns do anything.
	always_comb
	begin
		op_next = OP_NONE;
		if (instr_reg[15:8] == `MMN_OPC_LDL)
			op_next = OP_LDL;
		else if (instr_reg[15:8] == `MMN_OPC_MULL)
			op_next = OP_MULL;
		else if (instr_reg[15:8] == `MMN_OPC_LDB)
			op_next = OP_LDB;
		else if (instr_reg[15:9] == `MMN_OPC_ST)
			op_next = OP_ST;
		else if (instr_reg[15:9] == `MMN_OPC_MULF)
			op_next = OP_MULF;
		else if (instr_reg[15:9] == `MMN_OPC_NEG)
			op_next = OP_NEG;
	end

	// Indexed offset takes precedence over the plain access bank.
	always_comb
	begin
		if (abit)
			eff_addr = {bank_selector_register[3:0], fval};
		else if (ext_reg && fval <= `MMN_IDX_LIMIT)
			eff_addr = 12'(index_reg + 12'(fval));
		else if (fval < `MMN_ACC_SPLIT)
			eff_addr = {4'h0, fval};
		else
			eff_addr = {`MMN_SFR_PAGE, fval};
	end

	mmn_alu u_alu
	(
		.acc(acc_reg),
		.opnd(opnd_reg),
		.res(alu_out)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------

	assign access = ce && psel && penable && pready_reg;
	assign wr = access && pwrite && hit;

	// Read mux; low address bits must be zero to hit a register.
	always_comb
	begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`MMN_OFF_CTRL: rd_mux = {31'h0, ext_reg};
			`MMN_OFF_INSTR: rd_mux = {15'h0, busy, instr_reg};
			`MMN_OFF_ACC: rd_mux = {24'h0, acc_reg};
			`MMN_OFF_BANK: rd_mux = {24'h0, bank_selector_register};
			`MMN_OFF_PROD: rd_mux = {16'h0, product_high_byte, product_low_byte};
			`MMN_OFF_STATUS: rd_mux = {27'h0, status_reg};
			`MMN_OFF_INDEX: rd_mux = {20'h0, index_reg};
			`MMN_OFF_MADDR: rd_mux = {20'h0, maddr_reg};
			`MMN_OFF_MDATA: rd_mux = {24'h0, mem[maddr_reg[IW-1:0]]};
			default: hit = 1'b0;
		endcase
	end

	// Ready rises one cycle after setup and is held off while an
	// instruction runs, so software never races the sequencer.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready_reg <= psel && !pready_reg && !busy;
			pslverr_reg <= psel && !pready_reg && !busy && !hit;
			prdata_reg <= (psel && !pready_reg && hit) ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign busy = busy_reg;

	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------

	// A write to the instruction register starts one four-phase cycle.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= ST_IDLE;
			instr_reg <= 16'h0000;
			op_reg <= OP_NONE;
			busy_reg <= 1'b0;
		end
		else if (ce)
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					if (wr && paddr == `MMN_OFF_INSTR)
					begin
						instr_reg <= pwdata[15:0];
						state_reg <= ST_Q1;
						busy_reg <= 1'b1;
					end
				end
				ST_Q1:
				begin
					op_reg <= op_next;
					state_reg <= ST_Q2;
				end
				ST_Q2: state_reg <= ST_Q3;
				ST_Q3: state_reg <= ST_Q4;
				ST_Q4:
				begin
					// Busy falls with the return to idle, so it always matches the state.
					state_reg <= ST_IDLE;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	// Phase two reads the operand, phase three processes it.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_reg <= `MMN_RST_ADDR;
			opnd_reg <= `MMN_RST_BYTE;
			alu_reg <= '0;
		end
		else if (ce)
		begin
			if (state_reg == ST_Q2)
			begin
				addr_reg <= eff_addr;
				// Literal multiply uses the immediate as its operand.
				opnd_reg <= (op_reg == OP_MULL) ? fval : mem[eff_addr[IW-1:0]];
			end
			if (state_reg == ST_Q3)
				alu_reg <= alu_out;
		end
	end

	// ----------------------------------------------------------------
	// Destinations, written in phase four or by software when idle
	// ----------------------------------------------------------------

	logic q4;
	assign q4 = (state_reg == ST_Q4);

	// Working register; multiplies and stores leave it alone.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			acc_reg <= `MMN_RST_BYTE;
		else if (ce && q4 && op_reg == OP_LDL)
			acc_reg <= fval;
		else if (wr && paddr == `MMN_OFF_ACC)
			acc_reg <= pwdata[7:0];
	end

	// Bank selector; the upper nibble can never become non-zero.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			bank_selector_register <= `MMN_RST_BYTE;
		else if (ce && q4 && op_reg == OP_LDB)
			bank_selector_register <= {4'h0, fval[3:0]};
		else if (wr && paddr == `MMN_OFF_BANK)
			bank_selector_register <= {4'h0, pwdata[3:0]};
	end

	// Product pair, high byte in the upper register.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			product_high_byte <= `MMN_RST_BYTE;
			product_low_byte <= `MMN_RST_BYTE;
		end
		else if (ce && q4 && (op_reg == OP_MULL || op_reg == OP_MULF))
		begin
			product_high_byte <= alu_reg.prod[15:8];
			product_low_byte <= alu_reg.prod[7:0];
		end
		else if (wr && paddr == `MMN_OFF_PROD)
		begin
			product_high_byte <= pwdata[15:8];
			product_low_byte <= pwdata[7:0];
		end
	end

	// Status flags move only on a negate; every other op keeps them.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			status_reg <= `MMN_RST_STATUS;
		else if (ce && q4 && op_reg == OP_NEG)
			status_reg <= alu_reg.flags;
		else if (wr && paddr == `MMN_OFF_STATUS)
			status_reg <= pwdata[4:0];
	end

	// Software-only control: extended set, index base, memory pointer.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_reg <= 1'b0;
			index_reg <= `MMN_RST_ADDR;
			maddr_reg <= `MMN_RST_ADDR;
		end
		else
		begin
			if (wr && paddr == `MMN_OFF_CTRL)
				ext_reg <= pwdata[`MMN_CTRL_EXT];
			if (wr && paddr == `MMN_OFF_INDEX)
				index_reg <= pwdata[11:0];
			if (wr && paddr == `MMN_OFF_MADDR)
				maddr_reg <= pwdata[11:0];
		end
	end

	// File memory; addresses beyond the depth wrap onto it.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < MEM_DEPTH; i++)
				mem[i] <= `MMN_RST_BYTE;
		end
		else if (ce && q4 && op_reg == OP_ST)
			mem[addr_reg[IW-1:0]] <= acc_reg;
		else if (ce && q4 && op_reg == OP_NEG)
			mem[addr_reg[IW-1:0]] <= alu_reg.neg;
		else if (wr && paddr == `MMN_OFF_MDATA)
			mem[maddr_reg[IW-1:0]] <= pwdata[7:0];
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic q4e;
	assign q4e = ce && q4;

	literal_load_a: assert property ((q4e && op_reg == OP_LDL) |=>
		acc_reg == $past(fval) && status_reg == $past(status_reg))
		else $error("literal load wrong");
	store_file_a: assert property ((q4e && op_reg == OP_ST) |=>
		mem[$past(addr_reg[IW-1:0])] == $past(acc_reg))
		else $error("store wrong");
	bank_addr_a: assert property ((ce && state_reg == ST_Q2 && abit) |=>
		addr_reg == {bank_selector_register[3:0], $past(fval)})
		else $error("bank address wrong");
	indexed_addr_a: assert property ((ce && state_reg == ST_Q2 && !abit && ext_reg
		&& fval <= `MMN_IDX_LIMIT) |=> addr_reg == 12'($past(index_reg) + 12'($past(fval))))
		else $error("indexed address wrong");
	lit_multiply_a: assert property ((q4e && op_reg == OP_MULL) |=>
		{product_high_byte, product_low_byte} == 16'($past(acc_reg)) * 16'($past(fval))
		&& acc_reg == $past(acc_reg))
		else $error("literal multiply wrong");
	file_multiply_a: assert property ((q4e && op_reg == OP_MULF) |=>
		{product_high_byte, product_low_byte} == 16'($past(acc_reg)) * 16'($past(opnd_reg))
		&& mem[$past(addr_reg[IW-1:0])] == $past(opnd_reg))
		else $error("file multiply wrong");
	mul_flags_a: assert property ((q4e && (op_reg == OP_MULL || op_reg == OP_MULF))
		|=> $stable(status_reg))
		else $error("multiply touched status");
	negate_file_a: assert property ((q4e && op_reg == OP_NEG) |=>
		mem[$past(addr_reg[IW-1:0])] == 8'(~$past(opnd_reg) + 8'h01)
		&& status_reg[`MMN_ST_Z] == ($past(opnd_reg) == 8'h00)
		&& status_reg[`MMN_ST_C] == ($past(opnd_reg) == 8'h00))
		else $error("negate wrong");
	bank_nibble_a: assert property (bank_selector_register[7:4] == 4'h0)
		else $error("bank upper nibble set");
	four_phase_a: assert property ((state_reg == ST_Q1 && ce ##1 ce ##1 ce ##1 ce)
		|=> state_reg == ST_IDLE)
		else $error("instruction not four phases");

	mull_cov: cover property (q4e && op_reg == OP_MULL);
	neg_zero_cov: cover property (q4e && op_reg == OP_NEG && opnd_reg == 8'h00);
	indexed_cov: cover property (ce && state_reg == ST_Q2 && !abit && ext_reg
		&& fval <= `MMN_IDX_LIMIT);
	bank_load_cov: cover property (q4e && op_reg == OP_LDB && fval[7:4] != 4'h0);

endmodule

/* hw/mmn_consts.svh */
`ifndef MMN_CONSTS_SVH
`define MMN_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the bus)
// ----------------------------------------------------------------
`define MMN_OFF_CTRL 12'h000
`define MMN_OFF_INSTR 12'h004
`define MMN_OFF_ACC 12'h008
`define MMN_OFF_BANK 12'h00c
`define MMN_OFF_PROD 12'h010
`define MMN_OFF_STATUS 12'h014
`define MMN_OFF_INDEX 12'h018
`define MMN_OFF_MADDR 12'h01c
`define MMN_OFF_MDATA 12'h020

// ----------------------------------------------------------------
// Opcode patterns and operand fields
// ----------------------------------------------------------------
`define MMN_OPC_LDL 8'h0e
`define MMN_OPC_MULL 8'h0d
`define MMN_OPC_LDB 8'h01
`define MMN_OPC_ST 7'h37
`define MMN_OPC_NEG 7'h36
`define MMN_OPC_MULF 7'h01
`define MMN_IDX_LIMIT 8'h5f
`define MMN_ACC_SPLIT 8'h80
`define MMN_SFR_PAGE 4'hf

// ----------------------------------------------------------------
// Status bit positions, control bits and reset values
// ----------------------------------------------------------------
`define MMN_ST_C 0
`define MMN_ST_DC 1
`define MMN_ST_Z 2
`define MMN_ST_OV 3
`define MMN_ST_N 4
`define MMN_CTRL_EXT 0
`define MMN_BUSY_BIT 16
`define MMN_RST_BYTE 8'h00
`define MMN_RST_STATUS 5'h00
`define MMN_RST_ADDR 12'h000

`endif

/* hw/mmn_pkg.sv */
package mmn_pkg;

	// One-hot sequencer: idle plus the four phases of an instruction cycle.
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_Q1 = 5'h02,
		ST_Q2 = 5'h04,
		ST_Q3 = 5'h08,
		ST_Q4 = 5'h10
	} mmn_state_t;

	// Decoded operation; anything unrecognised runs as a no-operation.
	typedef enum logic [2:0]
	{
		OP_NONE = 3'h0,
		OP_LDL = 3'h1,
		OP_ST = 3'h2,
		OP_MULL = 3'h3,
		OP_MULF = 3'h4,
		OP_NEG = 3'h5,
		OP_LDB = 3'h6
	} mmn_op_t;

	// Results of the arithmetic unit travel together.
	typedef struct packed
	{
		logic [15:0] prod;
		logic [7:0] neg;
		logic [4:0] flags;
	} mmn_alu_t;

endpackage

/* hw/mmn_alu.sv */
`timescale 1ns/1ns
`include "mmn_consts.svh"

module mmn_alu
	import mmn_pkg::*;
(
	// Operands.
	input wire logic [7:0] acc,
	input wire logic [7:0] opnd,
	// Results.
	output mmn_pkg::mmn_alu_t res
);

	// ----------------------------------------------------------------
	// Multiply and negate
	// ----------------------------------------------------------------

	// Inverted operand plus one, nine bits so the carry out is kept.
	logic [8:0] neg_sum;
	// Low nibble sum, five bits for the digit carry.
	logic [4:0] nib_sum;

	// Pure combinational; the sequencer registers the result in phase three.
	always_comb
	begin
		neg_sum = {1'b0, ~opnd} + 9'h001;
		nib_sum = {1'b0, ~opnd[3:0]} + 5'h01;
		res.prod = 16'(acc) * 16'(opnd);
		res.neg = neg_sum[7:0];
		res.flags = `MMN_RST_STATUS;
		// Carry and digit carry are the carries of the add-one step.
		res.flags[`MMN_ST_C] = neg_sum[8];
		res.flags[`MMN_ST_DC] = nib_sum[4];
		res.flags[`MMN_ST_Z] = (neg_sum[7:0] == 8'h00);
		// Only the most negative value overflows when negated.
		res.flags[`MMN_ST_OV] = (opnd == 8'h80);
		res.flags[`MMN_ST_N] = neg_sum[7];
	end

endmodule

/* test/tb.sv */
`timescale 1ns/1ns
`include "mmn_consts.svh"

module tb;
	import mmn_pkg::*;
	// -----------------------------------------------------------
	// Signals
	// -----------------------------------------------------------
	// Clock, reset and clock enable.
	logic clk;
	logic rstn;
	logic ce;
	// Register bus.
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic busy;
	// Bookkeeping and the last read result.
	int err_total;
	int compares;
	int cycles;
	logic [31:0] rd;
	logic er;
	// Store targets as {bank bit, file address} and the resulting memory address.
	logic [8:0] st_op [6] = '{9'h010, 9'h090, 9'h120, 9'h05f, 9'h05f, 9'h060};
	logic [11:0] st_ad [6] = '{12'h010, 12'hf90, 12'h520, 12'h05f, 12'h35f, 12'h060};
	logic [7:0] neg_in [5] = '{8'h3a, 8'h00, 8'h80, 8'h01, 8'h10};

	mmn_core #(.MEM_DEPTH(4096)) u_dut (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.busy(busy)
	);

	// The clock toggles every half period of 5 ns.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// A hung handshake is cut short well beyond the expected run length.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			end_of_test();
		end
	end

	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus transfer; the setup starts at the next rising edge, so the
	// release of a previous transfer never shares a time step with it.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads a register and compares it.
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// Sets a file memory byte through the pointer and data registers.
	task automatic mset(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, `MMN_OFF_MADDR, {20'h0, a});
		apb(1'b1, `MMN_OFF_MDATA, {24'h0, d});
	endtask

	// Reads back a file memory byte.
	task automatic mchk(input logic [11:0] a, input logic [7:0] e, input string nm);
		apb(1'b1, `MMN_OFF_MADDR, {20'h0, a});
		rchk(`MMN_OFF_MDATA, {24'h0, e}, nm);
	endtask

	// Runs one instruction, holds the enable low for hold cycles after the
	// start, and counts the cycles for which busy stands.
	task automatic exec_hold(input logic [15:0] ins, input int hold);
		int n;
		n = 0;
		apb(1'b1, `MMN_OFF_INSTR, {16'h0, ins});
		ce <= (hold == 0);
		for (int k = 0; k < 12 + hold; k++)
		begin
			@(posedge clk);
			if (k == hold - 1)
				ce <= 1'b1;
			if (busy === 1'b1)
				n++;
		end
		chk("busy cycles", 32'(4 + hold), n);
	endtask

	// Runs one instruction with the enable high throughout.
	task automatic exec(input logic [15:0] ins);
		exec_hold(ins, 0);
	endtask

	// Expected flags after negation: N, OV, Z, DC, C from bit 4 down.
	function automatic logic [31:0] nflags(input logic [7:0] o);
		logic [7:0] r;
		r = ~o + 8'h01;
		return {27'h0, r[7], o == 8'h80, o == 8'h00, o[3:0] == 4'h0, o == 8'h00};
	endfunction

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// -----------------------------------------------------------
	// Test sequence
	// -----------------------------------------------------------
	initial
	begin
		err_total = 0;
		compares = 0;
		cycles = 0;
		rstn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rchk(`MMN_OFF_ACC, 32'h0, "acc reset");
		rchk(`MMN_OFF_BANK, 32'h0, "bank reset");
		rchk(`MMN_OFF_PROD, 32'h0, "prod reset");
		apb(1'b0, 12'h024, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("test reset done");
		// Preset every flag so that a stray clear shows up.
		apb(1'b1, `MMN_OFF_STATUS, 32'h1f);
		exec({`MMN_OPC_LDL, 8'h5a});
		rchk(`MMN_OFF_ACC, 32'h5a, "acc load");
		rchk(`MMN_OFF_STATUS, 32'h1f, "status load");
		exec({`MMN_OPC_LDB, 8'hff});
		rchk(`MMN_OFF_BANK, 32'h0f, "bank nibble");
		exec({`MMN_OPC_LDB, 8'h05});
		rchk(`MMN_OFF_BANK, 32'h05, "bank load");
		$display("test load done");
		// Stores through access bank, selector and indexed offset.
		apb(1'b1, `MMN_OFF_INDEX, 32'h300);
		for (int i = 0; i < 6; i++)
		begin
			if (i == 4)
				apb(1'b1, `MMN_OFF_CTRL, 32'h1);
			exec({`MMN_OPC_LDL, 8'h40 + 8'(i)});
			exec({`MMN_OPC_ST, st_op[i]});
			mchk(st_ad[i], 8'h40 + 8'(i), "store byte");
		end
		rchk(`MMN_OFF_STATUS, 32'h1f, "status store");
		$display("test store done");
		exec({`MMN_OPC_LDL, 8'he2});
		exec({`MMN_OPC_MULL, 8'hc4});
		rchk(`MMN_OFF_PROD, 32'had08, "prod literal");
		rchk(`MMN_OFF_ACC, 32'he2, "acc kept");
		rchk(`MMN_OFF_STATUS, 32'h1f, "status mul");
		// A zero product must not raise any flag.
		apb(1'b1, `MMN_OFF_STATUS, 32'h0);
		exec({`MMN_OPC_MULL, 8'h00});
		rchk(`MMN_OFF_PROD, 32'h0, "prod zero");
		rchk(`MMN_OFF_STATUS, 32'h0, "status zero");
		mset(12'h530, 8'hb5);
		exec({`MMN_OPC_LDL, 8'hc4});
		exec({`MMN_OPC_MULF, 1'b1, 8'h30});
		rchk(`MMN_OFF_PROD, 32'h8a94, "prod file");
		mchk(12'h530, 8'hb5, "file kept");
		rchk(`MMN_OFF_ACC, 32'hc4, "acc kept file");
		rchk(`MMN_OFF_STATUS, 32'h0, "status mul file");
		// A frozen enable stretches the cycle and loses nothing.
		exec_hold({`MMN_OPC_MULL, 8'h02}, 3);
		rchk(`MMN_OFF_PROD, 32'h188, "prod frozen");
		$display("test multiply done");
		for (int i = 0; i < 5; i++)
		begin
			mset(12'h531, neg_in[i]);
			exec({`MMN_OPC_NEG, 1'b1, 8'h31});
			mchk(12'h531, ~neg_in[i] + 8'h01, "negated byte");
			rchk(`MMN_OFF_STATUS, nflags(neg_in[i]), "negate flags");
		end
		$display("test negate done");
		end_of_test();
	end
endmodule
